// [core/power_state_sleep_manager.sv]
// Power manager state machine with sleep, retention and supply fault reporting.
// Assumes supply compare flags are asynchronous pins and the bus is AHB-Lite.
//////////////////////////////////////////////////////////////////////////////
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
module power_state_sleep_manager
   import pwr_mgr_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              ce,
   // AHB-Lite slave.
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // Pins and supply monitors.
   input  wire logic              power_down_n,
   input  wire logic              switched_core_supply,
   input  wire logic [NUM_SUP-1:0] supply_por_ok,
   input  wire logic [NUM_SUP-1:0] post_switch_ok,
   input  wire supply_mon_t       supply_mon,
   // Power control outputs.
   output logic                   power_stable,
   output logic [RAMP_STEPS-1:0]  core_switch_en,
   output logic                   pm_blocks_en,
   output logic                   clocks_en,
   output logic                   xtal_start,
   output logic                   cal_start,
   output logic                   link_start,
   output logic                   link_hold,
   output logic                   fault_out_n
);

   localparam int unsigned SYNC_W = 2 + 2 * NUM_SUP + 2 * NUM_SUP;

   //////////////////////////////////////////////////////////////////////////////
   // Three-stage input synchronisers; a change counts when stages two and three agree.
   logic [SYNC_W-1:0] s1_r;
   logic [SYNC_W-1:0] s2_r;
   logic [SYNC_W-1:0] s3_r;
   logic [SYNC_W-1:0] clean_r;
   wire  [SYNC_W-1:0] raw_in = {power_down_n, switched_core_supply, supply_por_ok, post_switch_ok,
                                supply_mon};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_r    <= '0;
         s2_r    <= '0;
         s3_r    <= '0;
         clean_r <= '0;
      end else if (ce) begin
         s1_r    <= raw_in;
         s2_r    <= s1_r;
         s3_r    <= s2_r;
         clean_r <= (s2_r & s3_r) | (clean_r & (s2_r | s3_r));
      end
   end

   wire                pd_n_q   = clean_r[SYNC_W-1];
   wire                core_q   = clean_r[SYNC_W-2];
   wire [NUM_SUP-1:0]  por_q    = clean_r[SYNC_W-3 -: NUM_SUP];
   wire [NUM_SUP-1:0]  post_q   = clean_r[SYNC_W-3-NUM_SUP -: NUM_SUP];
   wire supply_mon_t   mon_q    = clean_r[2*NUM_SUP-1:0];

   wire power_down_req = !pd_n_q || !core_q || !(&por_q);
   wire all_post_ok    = &post_q;
   wire supply_fail    = (|mon_q.under) || (|mon_q.over);

   //////////////////////////////////////////////////////////////////////////////
   // Bus slave: one-cycle address capture, zero-wait data phase.
   logic       wr_pend_r;
   logic [7:0] addr_r;
   wire        bus_take  = hsel && htrans[1] && hready;
   wire        wr_take   = bus_take && hwrite;
   wire        wr_now    = wr_pend_r;
   wire        wr_ctrl   = wr_now && (addr_r == OFF_CTRL);
   wire        wr_cfg    = wr_now && (addr_r == OFF_CFG);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         addr_r    <= 8'h00;
      end else if (ce && hready) begin
         wr_pend_r <= wr_take;
         addr_r    <= haddr[7:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // State machine and control registers.
   pm_state_t                state_r;
   pm_state_t                state_nxt;
   logic [4:0]               ctrl_r;
   logic [4:0]               ctrl_nxt;
   logic [31:0]              cfg_r;
   logic [31:0]              cfg_nxt;
   logic [RAMP_STEPS-1:0]    sw_r;
   logic [7:0]               ramp_cnt_r;
   logic                     run_pulse_r;
   logic [2*NUM_SUP-1:0]     fail_latch_r;
   logic                     save_stb;
   retain_t                  held;
   logic                     held_valid;

   wire in_run     = (state_r == ST_RUN);
   wire sleep_wr   = wr_ctrl && hwdata[CTRL_SLEEP];
   wire sleep_go   = in_run && sleep_wr;
   wire wake_evt   = (state_r == ST_SLEEP) && bus_take;
   wire ramp_done  = &sw_r;
   wire soft_rst   = wr_ctrl && hwdata[CTRL_SRST] && in_run;

   assign save_stb = sleep_go;
   wire retain_t save_word = '{ctrl: (ctrl_r | 5'h01) & 5'h0F, cfg: cfg_r};

   retention_store u_ret (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .ce         (ce),
      .save_stb   (save_stb),
      .save_data  (save_word),
      .held_data  (held),
      .held_valid (held_valid)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF:   if (!power_down_req) state_nxt = ST_BOOT;
         ST_BOOT:  if (ramp_done && all_post_ok) state_nxt = ST_RUN;
         ST_RUN:   if (sleep_go) state_nxt = ST_SAVE;
                   else if (soft_rst && held_valid && held.ctrl[CTRL_SLEEP]) state_nxt = ST_SAVE;
         ST_SAVE:  state_nxt = ST_SAVED;
         ST_SAVED: state_nxt = ST_SLEEP;
         ST_SLEEP: if (wake_evt) state_nxt = ST_BOOT;
         default:  state_nxt = ST_OFF;
      endcase
      if (power_down_req)
         state_nxt = ST_OFF;
   end

   always_comb begin
      ctrl_nxt = ctrl_r;
      cfg_nxt  = cfg_r;
      if (state_r == ST_OFF) begin
         ctrl_nxt = CTRL_RESET;
         cfg_nxt  = CFG_RESET;
      end else if (state_r == ST_SLEEP && wake_evt && held_valid) begin
         ctrl_nxt = held.ctrl;
         cfg_nxt  = held.cfg;
      end else if (soft_rst) begin
         ctrl_nxt = held_valid ? held.ctrl : CTRL_RESET;
         cfg_nxt  = held_valid ? held.cfg : CFG_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_nxt = hwdata[4:0] & 5'h0F;
            if (!in_run)
               ctrl_nxt[CTRL_SLEEP] = ctrl_r[CTRL_SLEEP];
         end
         if (wr_cfg)
            cfg_nxt = hwdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= ST_OFF;
         ctrl_r  <= CTRL_RESET;
         cfg_r   <= CFG_RESET;
      end else if (ce) begin
         state_r <= state_nxt;
         ctrl_r  <= ctrl_nxt;
         cfg_r   <= cfg_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Gradual switch ramp limits in-rush; one switch group per step.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_r       <= '0;
         ramp_cnt_r <= 8'h00;
      end else if (ce) begin
         if (state_r != ST_BOOT && state_r != ST_RUN) begin
            sw_r       <= '0;
            ramp_cnt_r <= 8'h00;
         end else if (!ramp_done) begin
            if (ramp_cnt_r == 8'(RAMP_STEP_CYC - 1)) begin
               ramp_cnt_r <= 8'h00;
               sw_r       <= {sw_r[RAMP_STEPS-2:0], 1'b1};
            end else begin
               ramp_cnt_r <= ramp_cnt_r + 8'h01;
            end
         end
      end
   end

   // Failure latches survive power down; only the always-on reset clears them.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         fail_latch_r <= '0;
      else if (ce)
         fail_latch_r <= fail_latch_r | mon_q;
   end

   //////////////////////////////////////////////////////////////////////////////
   // Registered outputs.
   wire entering_run = (state_r == ST_BOOT) && (state_nxt == ST_RUN);
   wire [31:0] status_word = {26'h0, held_valid, supply_fail, state_r, power_stable};
   logic [31:0] rd_mux;

   always_comb begin
      case (haddr[7:0])
         OFF_CTRL:   rd_mux = {27'h0, ctrl_r};
         OFF_STATUS: rd_mux = status_word;
         OFF_POWER_STATUS_FIRST:   rd_mux = {28'h0, fail_latch_r[2*NUM_SUP-1:NUM_SUP]};
         OFF_POWER_STATUS_SECOND:   rd_mux = {28'h0, fail_latch_r[NUM_SUP-1:0]};
         OFF_CFG:    rd_mux = cfg_r;
         default:    rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata         <= 32'h0000_0000;
         hreadyout      <= 1'b1;
         hresp          <= 1'b0;
         power_stable   <= 1'b0;
         core_switch_en <= '0;
         pm_blocks_en   <= 1'b0;
         clocks_en      <= 1'b0;
         xtal_start     <= 1'b0;
         cal_start      <= 1'b0;
         link_start     <= 1'b0;
         link_hold      <= 1'b0;
         fault_out_n    <= 1'b1;
      end else if (ce) begin
         hrdata         <= (bus_take && !hwrite) ? rd_mux : 32'h0000_0000;
         hreadyout      <= 1'b1;
         hresp          <= 1'b0;
         power_stable   <= (state_r != ST_OFF) && !power_down_req;
         core_switch_en <= sw_r;
         pm_blocks_en   <= (state_r == ST_BOOT) || in_run;
         clocks_en      <= (state_r != ST_SAVED) && (state_r != ST_SLEEP) && (state_r != ST_OFF);
         xtal_start     <= entering_run;
         cal_start      <= entering_run;
         link_start     <= entering_run;
         link_hold      <= ctrl_r[CTRL_HOLD];
         fault_out_n    <= !(supply_fail || (|fail_latch_r));
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Checks.
   sleep_ignored_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && sleep_wr && !in_run && state_r != ST_OFF) |=> state_r != ST_SAVE)
      else $error("sleep request outside run started a save");
   save_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && sleep_go && !power_down_req) |=> (state_r == ST_SAVE) && held_valid)
      else $error("sleep request in run did not save");
   saved_sleep_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && state_r == ST_SAVED && !power_down_req) |=> state_r == ST_SLEEP ##1 !clocks_en)
      else $error("saved state did not reach sleep with clocks off");
   pd_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && power_down_req) |=> state_r == ST_OFF)
      else $error("power down request not honoured");
   pd_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && state_r == ST_OFF && !power_down_req) |=> state_r == ST_BOOT)
      else $error("release did not enter boot");
   run_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_r == ST_BOOT && $past(state_r) != ST_BOOT) |-> !(&sw_r))
      else $error("boot entered with switches already on");
   run_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && entering_run) |=> xtal_start && cal_start && link_start)
      else $error("run entry did not start warm-up");
   fault_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && supply_fail) |=> !fault_out_n)
      else $error("fault output not driven low");
   pd_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && state_r == ST_OFF) |=> ctrl_r == CTRL_RESET)
      else $error("power down did not clear control");
   wake_restore_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && wake_evt && held_valid && !power_down_req) |=> cfg_r == $past(held.cfg))
      else $error("wake did not restore configuration");
   stable_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && state_r == ST_RUN && !power_down_req) |=> power_stable)
      else $error("power stable missing in run");
   one_of_states_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_r inside {ST_OFF, ST_BOOT, ST_RUN, ST_SAVE, ST_SAVED, ST_SLEEP})
      else $error("illegal power state");
   softrst_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && soft_rst && held_valid && held.ctrl[CTRL_SLEEP] && !power_down_req) |=> state_r == ST_SAVE)
      else $error("soft reset did not re-enter sleep");
   ramp_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && $past(ce) && state_r == ST_BOOT && $past(state_r) == ST_BOOT) |-> $countones(sw_r) <= $countones($past(sw_r)) + 1)
      else $error("switches turned on more than one step at once");

   reach_run_c:   cover property (@(posedge hclk) disable iff (!hresetn) state_r == ST_RUN);
   reach_sleep_c: cover property (@(posedge hclk) disable iff (!hresetn) state_r == ST_SLEEP);
   wake_c:        cover property (@(posedge hclk) disable iff (!hresetn) wake_evt);
   fault_c:       cover property (@(posedge hclk) disable iff (!hresetn) !fault_out_n);

endmodule

// [core/retention_store.sv]
// Always-on retention store holding a snapshot of control and configuration.
// Assumes it is never reset by the power-down path; only its own hresetn clears it.
module retention_store
   import pwr_mgr_pkg::*;
(
   // Clock and reset.
   input  wire logic    hclk,
   input  wire logic    hresetn,
   input  wire logic    ce,
   // Save and restore.
   input  wire logic    save_stb,
   input  wire retain_t save_data,
   output retain_t      held_data,
   output logic         held_valid
);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         held_data  <= '{ctrl: CTRL_RESET, cfg: CFG_RESET};
         held_valid <= 1'b0;
      end else if (ce && save_stb) begin
         held_data  <= save_data;
         held_valid <= 1'b1;
      end
   end

endmodule

// [include/pwr_mgr_pkg.sv]
// Package for the power state and sleep manager: register map, fields, states, timing.
// Assumes a 25 MHz hclk and an AHB-Lite register bus with 32-bit data.
package pwr_mgr_pkg;

   localparam int unsigned CLK_MHZ        = 25;
   localparam int unsigned RAMP_STEP_NS   = 400;
   localparam int unsigned RAMP_STEP_CYC  = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RAMP_STEPS     = 4;

   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_POWER_STATUS_FIRST   = 8'h08;
   localparam logic [7:0] OFF_POWER_STATUS_SECOND   = 8'h0C;
   localparam logic [7:0] OFF_CFG    = 8'h10;

   localparam int unsigned CTRL_SLEEP  = 0;
   localparam int unsigned CTRL_HOLD   = 1;
   localparam int unsigned CTRL_WAKE_A = 2;
   localparam int unsigned CTRL_WAKE_B = 3;
   localparam int unsigned CTRL_SRST   = 4;

   localparam logic [4:0]  CTRL_RESET = 5'h0C;
   localparam logic [31:0] CFG_RESET  = 32'h0000_0000;

   localparam int unsigned NUM_SUP = 4;

   typedef enum logic [2:0] {
      ST_OFF   = 3'b000,
      ST_BOOT  = 3'b001,
      ST_RUN   = 3'b011,
      ST_SAVE  = 3'b010,
      ST_SAVED = 3'b110,
      ST_SLEEP = 3'b111
   } pm_state_t;

   typedef struct packed {
      logic [NUM_SUP-1:0] under;
      logic [NUM_SUP-1:0] over;
   } supply_mon_t;

   typedef struct packed {
      logic [4:0]  ctrl;
      logic [31:0] cfg;
   } retain_t;

endpackage

// [verification/host_model.sv]
// Host side model: an AHB-Lite master that issues single word transfers.
// Assumes one slave whose hreadyout comes back as hready.
module host_model
(
   // Clock.
   input  wire logic        hclk,
   // Master outputs.
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   // Slave answer.
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   //////////////////////////////////////////////////////////////////////////////
   // The waits have no limit of their own, so the bench timeout cuts a hang short.
   // Released address and data are inverted so that a stale value never matches.
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      haddr <= ~a;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~d;
   endtask
endmodule

// [verification/test_power_state_sleep_manager.sv]
// Self-checking bench for the power state and sleep manager.
// Assumes host_model drives the register bus; pins and supplies come from here.
module test_power_state_sleep_manager
   import pwr_mgr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic                  hclk, hresetn, power_down_n, switched_core_supply;
   logic [NUM_SUP-1:0]    supply_por_ok, post_switch_ok;
   logic [RAMP_STEPS-1:0] core_switch_en;
   supply_mon_t           supply_mon;
   wire logic             hsel, hwrite, hready, hreadyout, hresp;
   wire logic [31:0]      haddr, hwdata, hrdata;
   wire logic [1:0]       htrans;
   wire logic [2:0]       hsize;
   logic                  power_stable, pm_blocks_en, clocks_en, xtal_start, cal_start, link_start;
   logic                  link_hold, fault_out_n, ret, ce;
   logic [31:0]           seed, rd, cfg_val;
   int                    fail_count = 0;
   int                    check_count = 0;
   int                    cycles = 0;

   assign hready = hreadyout;

   host_model host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

   power_state_sleep_manager dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .power_down_n(power_down_n),
      .switched_core_supply(switched_core_supply), .supply_por_ok(supply_por_ok),
      .post_switch_ok(post_switch_ok), .supply_mon(supply_mon), .power_stable(power_stable),
      .core_switch_en(core_switch_en), .pm_blocks_en(pm_blocks_en), .clocks_en(clocks_en),
      .xtal_start(xtal_start), .cal_start(cal_start), .link_start(link_start), .link_hold(link_hold),
      .fault_out_n(fault_out_n));

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   //////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic [31:0] exp_status(input pm_state_t st, input logic r);
      return {26'h0, r, 1'b0, st, 1'b1};
   endfunction

   task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_pin(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, {24'h0, a}, d, rd);
   endtask

   task automatic rd_reg(input logic [7:0] a);
      host.xfer(1'b0, {24'h0, a}, 32'h0, rd);
      check_pin("hresp", 1'b0, hresp);
   endtask

   task automatic wait_for(input string what, ref logic s, input logic v, input int n);
      int k;
      k = 0;
      while (s !== v && k < n) begin
         @(posedge hclk);
         #1;
         k++;
      end
      check_pin(what, v, s);
   endtask

   // The three start pulses must land together, and xtal_start must drop after one cycle.
   task automatic run_up();
      wait_for("xtal_start", xtal_start, 1'b1, 300);
      check_pin("cal_start", 1'b1, cal_start);
      check_pin("link_start", 1'b1, link_start);
      @(posedge hclk);
      #1;
      check_pin("xtal_start", 1'b0, xtal_start);
      check_reg("core_switch_en", {28'h0, {RAMP_STEPS{1'b1}}}, {28'h0, core_switch_en});
      rd_reg(OFF_STATUS);
      check_reg("status", exp_status(ST_RUN, ret), rd);
   endtask

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         print_verdict();
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   initial begin
      hresetn = 1'b0;
      ce = 1'b1;
      power_down_n = 1'b0;
      switched_core_supply = 1'b1;
      supply_por_ok = '1;
      post_switch_ok = '0;
      supply_mon = '0;
      seed = 32'h40;
      ret = 1'b0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      #1;
      check_pin("power_stable", 1'b0, power_stable);
      power_down_n <= 1'b1;
      wait_for("pm_blocks_en", pm_blocks_en, 1'b1, 50);
      // The ramp has just begun, so a frozen clock enable must hold every switch off.
      ce <= 1'b0;
      repeat (30) @(posedge hclk);
      #1;
      check_reg("frozen ramp", 32'h0, {28'h0, core_switch_en});
      ce <= 1'b1;
      repeat (60) @(posedge hclk);
      rd_reg(OFF_STATUS);
      check_reg("status", exp_status(ST_BOOT, 1'b0), rd);
      wr(OFF_CTRL, 32'hD);
      rd_reg(OFF_CTRL);
      check_reg("ctrl", {27'h0, CTRL_RESET}, rd);
      post_switch_ok <= '1;
      run_up();
      $display("Test boot done");
      for (int i = 0; i < 4; i++) begin
         seed = xorshift(seed);
         cfg_val = seed;
         wr(OFF_CFG, cfg_val);
         rd_reg(OFF_CFG);
         check_reg("cfg", cfg_val, rd);
      end
      wr(8'h20, seed);
      rd_reg(8'h20);
      check_reg("unmapped", 32'h0, rd);
      $display("Test registers done");
      wr(OFF_CTRL, 32'h2);
      @(posedge hclk);
      #1;
      check_pin("link_hold", 1'b1, link_hold);
      wr(OFF_CTRL, 32'h3);
      wait_for("clocks_en", clocks_en, 1'b0, 10);
      check_pin("pm_blocks_en", 1'b0, pm_blocks_en);
      check_reg("core_switch_en", 32'h0, {28'h0, core_switch_en});
      rd_reg(OFF_STATUS);
      check_reg("status asleep", exp_status(ST_SLEEP, 1'b1), rd);
      ret = 1'b1;
      run_up();
      rd_reg(OFF_CFG);
      check_reg("cfg restored", cfg_val, rd);
      wr(OFF_CTRL, 32'h0);
      @(posedge hclk);
      #1;
      check_pin("link_hold", 1'b0, link_hold);
      $display("Test sleep done");
      wr(OFF_CTRL, 32'h10);
      wait_for("clocks_en", clocks_en, 1'b0, 20);
      rd_reg(OFF_CFG);
      check_reg("cfg reloaded", cfg_val, rd);
      run_up();
      wr(OFF_CTRL, 32'h0);
      $display("Test soft reset done");
      check_pin("fault_out_n", 1'b1, fault_out_n);
      seed = xorshift(seed);
      supply_mon.under[seed[1:0]] <= 1'b1;
      supply_mon.over[seed[3:2]] <= 1'b1;
      // The input filter drops a one-cycle blip, so the fault stands for three cycles.
      repeat (3) @(posedge hclk);
      supply_mon <= '0;
      wait_for("fault_out_n", fault_out_n, 1'b0, 10);
      rd_reg(OFF_POWER_STATUS_FIRST);
      check_reg("power_status_first", 32'h1 << seed[1:0], rd);
      rd_reg(OFF_POWER_STATUS_SECOND);
      check_reg("power_status_second", 32'h1 << seed[3:2], rd);
      check_pin("fault_out_n", 1'b0, fault_out_n);
      $display("Test faults done");
      for (int c = 0; c < 3; c++) begin
         wr(OFF_CFG, xorshift(seed));
         @(posedge hclk);
         if (c == 0) power_down_n <= 1'b0;
         else if (c == 1) switched_core_supply <= 1'b0;
         else supply_por_ok[seed[5:4]] <= 1'b0;
         wait_for("power_stable", power_stable, 1'b0, 20);
         rd_reg(OFF_CFG);
         check_reg("cfg default", CFG_RESET, rd);
         rd_reg(OFF_POWER_STATUS_FIRST);
         check_reg("power_status_first kept", 32'h1 << seed[1:0], rd);
         power_down_n <= 1'b1;
         switched_core_supply <= 1'b1;
         supply_por_ok <= '1;
         run_up();
      end
      $display("Test power down done");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      #1;
      check_pin("fault_out_n", 1'b1, fault_out_n);
      check_pin("power_stable", 1'b0, power_stable);
      rd_reg(OFF_POWER_STATUS_FIRST);
      check_reg("power_status_first cleared", 32'h0, rd);
      $display("Test always-on reset done");
      print_verdict();
   end
endmodule
